// ---- shared/spcd_pkg.sv ----
// Package for the serial programming command decoder: opcodes, sizes, reset values, timing
`default_nettype none
package spcd_pkg;
	// Memory geometry (program memory as words, data memory as bytes)
	localparam int unsigned SPCD_PM_AW = 15;
	localparam int unsigned SPCD_PG_AW = 7;
	localparam int unsigned SPCD_DM_AW = 11;
	localparam int unsigned SPCD_PM_WORDS = 32768;
	localparam int unsigned SPCD_PG_WORDS = 128;
	localparam int unsigned SPCD_DM_BYTES = 2048;
	localparam int unsigned SPCD_BYTES_PER_INSTR = 4;
	// Instruction codes
	localparam logic [7:0] SPCD_OP_PREFIX = 8'hAC;
	localparam logic [7:0] SPCD_OP_ENABLE2 = 8'h53;
	localparam logic [3:0] SPCD_OP_PM_READ = 4'h2;
	localparam logic [3:0] SPCD_OP_PG_LOAD = 4'h4;
	localparam logic [7:0] SPCD_OP_PG_WRITE = 8'h4C;
	localparam logic [7:0] SPCD_OP_DM_READ = 8'hA0;
	localparam logic [7:0] SPCD_OP_DM_WRITE = 8'hC0;
	localparam logic [7:0] SPCD_OP_LOCK_RD = 8'h58;
	localparam logic [7:0] SPCD_OP_FUSE_RD = 8'h50;
	localparam logic [7:0] SPCD_SUB_ZERO = 8'h00;
	localparam logic [7:0] SPCD_SUB_HIGH = 8'h08;
	localparam logic [2:0] SPCD_SUB_ERASE = 3'h4;
	localparam logic [2:0] SPCD_SUB_LOCK_WR = 3'h7;
	localparam logic [7:0] SPCD_SUB_FUSE_LO = 8'hA0;
	localparam logic [7:0] SPCD_SUB_FUSE_HI = 8'hA8;
	localparam logic [7:0] SPCD_SUB_FUSE_EX = 8'hA4;
	// Values after reset or erase
	localparam logic [7:0] SPCD_ERASED = 8'hFF;
	localparam logic [5:0] SPCD_LOCK_RESET = 6'h3F;
	localparam logic [7:0] SPCD_FUSE_RESET = 8'hFF;
	localparam logic [1:0] SPCD_EFUSE_RESET = 2'h3;
	// Flash page write busy time
	localparam int unsigned SPCD_CLK_MHZ = 100;
	localparam int unsigned SPCD_T_FLASH_US = 4500;
	localparam int unsigned SPCD_FLASH_CYC = SPCD_T_FLASH_US * SPCD_CLK_MHZ;
	// Command states, Gray coded between idle and erase only; idle to page write flips both bits
	typedef enum logic [1:0] {
		SPCD_IDLE = 2'b00,
		SPCD_ERASE = 2'b01,
		SPCD_PGWR = 2'b11
	} spcd_state_t;
	// Decoded instruction carried from the link to the memories
	typedef struct packed {
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
	} spcd_instr_t;
endpackage : spcd_pkg
`default_nettype wire

// ---- rtl/spcd_decoder.sv ----
// Serial programming command decoder: four-byte instruction link with memories, lock and fuse bits
// Notes on behaviour
// [RULE_01] AC 53 xx xx under reset enables programming
// [RULE_02] AC 100xxxxx erases program and data memory
// [RULE_03] 0010H000 reads program memory byte H
// [RULE_04] 0100H000 loads page buffer, low before high
// [RULE_05] 4C commits page at page address
// [RULE_06] A0 reads data memory byte
// [RULE_07] C0 writes data memory byte
// [RULE_08] 58 00 returns six lock bits
// [RULE_09] AC 111xxxxx programs zero lock bits
// [RULE_10] AC A0/A8/A4 writes low/high/extended fuses
// [RULE_11] 50/58 reads return fuse bytes in byte four
// [RULE_12] Four bytes, MSB first, output in byte four
// [RULE_13] Third byte of enable echoes 0x53
// [RULE_14] Sample rising link edge, shift falling edge
// [RULE_15] Page under write reads 0xFF until done
// [RULE_16] Chip erase fills all memory with 0xFF
`default_nettype none
module spcd_decoder
	import spcd_pkg::*;
#(
	parameter int unsigned FLASH_CYC = SPCD_FLASH_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic dev_reset_n,
	input wire logic link_clk,
	input wire logic prog_serial_in,
	output logic prog_serial_out,
	output logic prog_enabled,
	output logic busy
);
	// Two-flop synchronisers for the pins
	logic [1:0] sck_sync_reg;
	logic [1:0] din_sync_reg;
	logic [1:0] rst_sync_reg;
	logic sck_prev_reg;
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_sync_reg <= 2'h0;
			din_sync_reg <= 2'h0;
			rst_sync_reg <= 2'h3;
			sck_prev_reg <= 1'b0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], link_clk};
			din_sync_reg <= {din_sync_reg[0], prog_serial_in};
			rst_sync_reg <= {rst_sync_reg[0], dev_reset_n};
			sck_prev_reg <= sck_sync_reg[1];
		end
	end
	wire logic sck_rise = sck_sync_reg[1] & ~sck_prev_reg;
	wire logic sck_fall = ~sck_sync_reg[1] & sck_prev_reg;
	wire logic in_prog = ~rst_sync_reg[1];

	// Storage
	logic [7:0] pm_lo_mem [SPCD_PM_WORDS];
	logic [7:0] pm_hi_mem [SPCD_PM_WORDS];
	logic [7:0] pg_lo_mem [SPCD_PG_WORDS];
	logic [7:0] pg_hi_mem [SPCD_PG_WORDS];
	logic [7:0] dm_mem [SPCD_DM_BYTES];
	logic [5:0] lock_reg;
	logic [7:0] fuse_lo_reg;
	logic [7:0] fuse_hi_reg;
	logic [1:0] fuse_ex_reg;

	// Shift-in state
	logic [31:0] sh_in_reg;
	logic [4:0] bit_cnt_reg;
	logic [7:0] sh_out_reg;
	logic done_reg;
	logic enabled_reg;
	spcd_state_t state_reg;
	logic [31:0] cyc_cnt_reg;
	logic [14:0] mem_idx_reg;
	logic [7:0] wr_page_reg;
	spcd_instr_t instr;
	assign instr = sh_in_reg;

	// Page address from command bytes: a[6:0] of byte two and b[7] of byte three
	function automatic logic [7:0] page_of(input logic [7:0] hi, input logic [7:0] lo);
		return {hi[6:0], lo[7]};
	endfunction : page_of

	// Bit shifting on link edges; counter wraps every four bytes
	always_ff @(posedge clk) begin
		if (reset || !in_prog) begin
			sh_in_reg <= 32'h0;
			bit_cnt_reg <= 5'h0;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			if (sck_rise) begin
				sh_in_reg <= {sh_in_reg[30:0], din_sync_reg[1]}; // MSB first [RULE_12] [RULE_14]
				bit_cnt_reg <= bit_cnt_reg + 5'h1;
				done_reg <= (bit_cnt_reg == 5'h1F); // Fourth byte complete [RULE_12]
			end
		end
	end

	// Read data reply: computed once three bytes are in, then shifted on falling edges
	wire logic third_done = sck_rise && (bit_cnt_reg == 5'h17);
	wire logic second_done = sck_rise && (bit_cnt_reg == 5'h0F);
	wire logic [7:0] b1_now = sh_in_reg[22:15];
	wire logic [7:0] b2_now = sh_in_reg[14:7];
	wire logic [7:0] b3_now = {sh_in_reg[6:0], din_sync_reg[1]};
	logic [7:0] reply;
	logic [14:0] rd_word;
	always_comb begin
		rd_word = {b2_now[6:0], b3_now};
		reply = 8'h00;
		if (b1_now[7:4] == SPCD_OP_PM_READ && b1_now[2:0] == 3'h0) begin
			if (state_reg == SPCD_PGWR && wr_page_reg == page_of(b2_now, b3_now))
				reply = SPCD_ERASED; // Busy page polls as 0xFF [RULE_15]
			else
				reply = b1_now[3] ? pm_hi_mem[rd_word] : pm_lo_mem[rd_word]; // [RULE_03]
		end else if (b1_now == SPCD_OP_DM_READ) begin
			reply = dm_mem[{b2_now[2:0], b3_now}]; // [RULE_06]
		end else if (b1_now == SPCD_OP_LOCK_RD && b2_now == SPCD_SUB_ZERO) begin
			reply = {2'h3, lock_reg}; // [RULE_08]
		end else if (b1_now == SPCD_OP_LOCK_RD && b2_now == SPCD_SUB_HIGH) begin
			reply = fuse_hi_reg; // [RULE_11]
		end else if (b1_now == SPCD_OP_FUSE_RD && b2_now == SPCD_SUB_ZERO) begin
			reply = fuse_lo_reg; // [RULE_11]
		end else if (b1_now == SPCD_OP_FUSE_RD && b2_now == SPCD_SUB_HIGH) begin
			reply = {6'h3F, fuse_ex_reg}; // [RULE_11]
		end
	end

	// Output shifter: loads after the second and third bytes, shifts out on falling link edge
	always_ff @(posedge clk) begin
		if (reset || !in_prog) begin
			sh_out_reg <= 8'h00;
			prog_serial_out <= 1'b0;
		end else if (second_done) begin
			// Echo of the second byte during the third byte keeps the programmer in sync
			sh_out_reg <= {sh_in_reg[6:0], din_sync_reg[1]}; // [RULE_13]
		end else if (third_done) begin
			sh_out_reg <= (enabled_reg ? reply : 8'h00); // Read data in byte four [RULE_12]
		end else if (sck_fall) begin
			prog_serial_out <= sh_out_reg[7]; // [RULE_14]
			sh_out_reg <= {sh_out_reg[6:0], 1'b0};
		end
	end

	// Programming enable follows the held device reset
	always_ff @(posedge clk) begin
		if (reset || !in_prog) begin
			enabled_reg <= 1'b0;
		end else if (done_reg && instr.b1 == SPCD_OP_PREFIX && instr.b2 == SPCD_OP_ENABLE2) begin
			enabled_reg <= 1'b1; // [RULE_01]
		end
	end

	// Long operations: erase walks every index, page write waits out the busy time
	wire logic go = done_reg && enabled_reg && state_reg == SPCD_IDLE;
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= SPCD_IDLE;
			cyc_cnt_reg <= 32'h0;
			mem_idx_reg <= 15'h0;
			wr_page_reg <= 8'h00;
		end else begin
			case (state_reg)
				SPCD_IDLE: begin
					mem_idx_reg <= 15'h0;
					cyc_cnt_reg <= 32'h0;
					if (go && instr.b1 == SPCD_OP_PREFIX && instr.b2[7:5] == SPCD_SUB_ERASE) begin
						state_reg <= SPCD_ERASE; // [RULE_02]
					end else if (go && instr.b1 == SPCD_OP_PG_WRITE) begin
						wr_page_reg <= page_of(instr.b2, instr.b3); // [RULE_05]
						state_reg <= SPCD_PGWR;
					end
				end
				SPCD_ERASE: begin
					mem_idx_reg <= mem_idx_reg + 15'h1;
					if (mem_idx_reg == 15'h7FFF)
						state_reg <= SPCD_IDLE;
				end
				SPCD_PGWR: begin
					mem_idx_reg <= {8'h00, mem_idx_reg[6:0] + 7'h1};
					cyc_cnt_reg <= cyc_cnt_reg + 32'h1;
					if (cyc_cnt_reg >= FLASH_CYC - 1)
						state_reg <= SPCD_IDLE; // Page readable again afterwards [RULE_15]
				end
				default: state_reg <= SPCD_IDLE;
			endcase
		end
	end

	// Program memory: erased word by word, page copied during busy time
	wire logic [14:0] pg_word = {wr_page_reg, mem_idx_reg[6:0]};
	always_ff @(posedge clk) begin
		if (state_reg == SPCD_ERASE) begin
			pm_lo_mem[mem_idx_reg] <= SPCD_ERASED; // [RULE_16]
			pm_hi_mem[mem_idx_reg] <= SPCD_ERASED;
		end else if (state_reg == SPCD_PGWR && cyc_cnt_reg < SPCD_PG_WORDS) begin
			pm_lo_mem[pg_word] <= pg_lo_mem[mem_idx_reg[6:0]]; // [RULE_05]
			pm_hi_mem[pg_word] <= pg_hi_mem[mem_idx_reg[6:0]];
		end
	end

	// Page buffer load; the high byte after the low byte of the same word is the programmer's duty
	always_ff @(posedge clk) begin
		if (go && instr.b1[7:4] == SPCD_OP_PG_LOAD && instr.b1[2:0] == 3'h0) begin
			if (instr.b1[3])
				pg_hi_mem[instr.b3[6:0]] <= instr.b4; // [RULE_04]
			else
				pg_lo_mem[instr.b3[6:0]] <= instr.b4; // [RULE_04]
		end
	end

	// Data memory: erase fills 0xFF, byte writes store byte four directly with no erase step
	always_ff @(posedge clk) begin
		if (state_reg == SPCD_ERASE && mem_idx_reg < SPCD_DM_BYTES) begin
			dm_mem[mem_idx_reg[10:0]] <= SPCD_ERASED; // [RULE_16]
		end else if (go && instr.b1 == SPCD_OP_DM_WRITE) begin
			dm_mem[{instr.b2[2:0], instr.b3}] <= instr.b4; // [RULE_07]
		end
	end

	// Lock and fuse bits; a lock can only be programmed, never released except by erase or reset
	always_ff @(posedge clk) begin
		if (reset) begin
			lock_reg <= SPCD_LOCK_RESET;
			fuse_lo_reg <= SPCD_FUSE_RESET;
			fuse_hi_reg <= SPCD_FUSE_RESET;
			fuse_ex_reg <= SPCD_EFUSE_RESET;
		end else if (state_reg == SPCD_ERASE) begin
			lock_reg <= SPCD_LOCK_RESET;
		end else if (go && instr.b1 == SPCD_OP_PREFIX) begin
			if (instr.b2[7:5] == SPCD_SUB_LOCK_WR)
				lock_reg <= lock_reg & instr.b4[5:0]; // [RULE_09]
			else if (instr.b2 == SPCD_SUB_FUSE_LO)
				fuse_lo_reg <= instr.b4; // [RULE_10]
			else if (instr.b2 == SPCD_SUB_FUSE_HI)
				fuse_hi_reg <= instr.b4; // [RULE_10]
			else if (instr.b2 == SPCD_SUB_FUSE_EX)
				fuse_ex_reg <= instr.b4[1:0]; // [RULE_10]
		end
	end

	// Status outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			prog_enabled <= 1'b0;
			busy <= 1'b0;
		end else begin
			prog_enabled <= enabled_reg;
			busy <= (state_reg != SPCD_IDLE);
		end
	end
endmodule : spcd_decoder
`default_nettype wire

// ---- tb/spcd_decoder_asserts.sv ----
// Checker: port timing of the serial programming command decoder
`default_nettype none
module spcd_decoder_asserts
	import spcd_pkg::*;
#(
	parameter int unsigned FLASH_CYC = SPCD_FLASH_CYC
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic dev_reset_n,
	input wire logic link_clk,
	input wire logic prog_serial_in,
	input wire logic prog_serial_out,
	input wire logic prog_enabled,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [31:0] busy_cnt_reg;
	// Length of the current busy spell; wide enough for the full-length page write time
	always_ff @(posedge clk) begin
		if (reset || !busy) begin
			busy_cnt_reg <= 32'h00000000;
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 32'h00000001;
		end
	end
	// Reset pin held for the depth of its synchroniser, or released
	sequence held_in_reset_s;
		(!dev_reset_n) [*3];
	endsequence
	sequence pin_released_s;
		dev_reset_n [*5];
	endsequence
	reset_clear_a: assert property ($fell(reset) |-> !prog_enabled && !busy && !prog_serial_out)
		else $error("outputs not clear after reset");
	en_drop_a: assert property (pin_released_s |-> !prog_enabled)
		else $error("enable kept with reset pin high");
	en_hold_a: assert property (held_in_reset_s ##0 prog_enabled |=> prog_enabled)
		else $error("enable lost under reset pin");
	en_cause_a: assert property ($rose(prog_enabled) |-> $past(!dev_reset_n, 3))
		else $error("enable without reset pin low");
	busy_cause_a: assert property ($rose(busy) |-> prog_enabled && $past(prog_enabled))
		else $error("busy while not enabled");
	// A spell is either the erase walk over every word or the page write time
	busy_len_a: assert property ($fell(busy) |-> busy_cnt_reg == SPCD_PM_WORDS ||
		(busy_cnt_reg >= FLASH_CYC - 1 && busy_cnt_reg <= FLASH_CYC))
		else $error("busy spell of wrong length");
	out_edge_a: assert property ($changed(prog_serial_out) && !dev_reset_n |-> !link_clk)
		else $error("data out moved while link high");
	out_hold_a: assert property ($rose(link_clk) |=> $stable(prog_serial_out) [*4])
		else $error("data out moved after rising link");
endmodule : spcd_decoder_asserts
bind spcd_decoder spcd_decoder_asserts #(.FLASH_CYC(FLASH_CYC)) chk_u (.clk(clk), .reset(reset),
	.dev_reset_n(dev_reset_n), .link_clk(link_clk), .prog_serial_in(prog_serial_in),
	.prog_serial_out(prog_serial_out), .prog_enabled(prog_enabled), .busy(busy));
`default_nettype wire

// ---- tb/spcd_prog_model.sv ----
// Behavioural programmer: drives link clock and data, collects the reply
`default_nettype none
module spcd_prog_model (
	output logic link_clk,
	output logic serial_in,
	input wire logic serial_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// Link parked low outside frames
	initial begin
		link_clk = 1'b0;
		serial_in = 1'b0;
	end
	// One instruction of four bytes, back to back, MSB first
	task automatic xfer(input logic [31:0] cmd, output logic [31:0] resp);
		for (int i = 31; i >= 0; i--) begin
			serial_in = cmd[i];
			#62.5 link_clk = 1'b1;
			resp[i] = serial_out;
			#62.5 link_clk = 1'b0;
		end
		serial_in = ~cmd[0]; // Released line never shows a stale bit
		#62.5; // Idle low half period, so back-to-back calls never drive a pin twice in one step
	endtask : xfer
endmodule : spcd_prog_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial programming command decoder
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned FLASH_N = 2000;
	logic clk, reset, dev_reset_n, link_clk, prog_serial_in, prog_serial_out, prog_enabled, busy;
	int err_count = 0;
	int comparisons = 0;
	logic [31:0] resp;
	spcd_decoder #(.FLASH_CYC(FLASH_N)) dut_u (.clk(clk), .reset(reset), .dev_reset_n(dev_reset_n),
		.link_clk(link_clk), .prog_serial_in(prog_serial_in), .prog_serial_out(prog_serial_out),
		.prog_enabled(prog_enabled), .busy(busy));
	spcd_prog_model prog_u (.link_clk(link_clk), .serial_in(prog_serial_in), .serial_out(prog_serial_out));
	// System clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic stop_test();
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte
	// Send one instruction and judge the masked byte four of the reply
	task automatic rd(input string what, input logic [31:0] c, input logic [7:0] exp, input logic [7:0] mask);
		prog_u.xfer(c, resp);
		check_byte(what, exp, resp[7:0] & mask);
	endtask : rd
	// Bounded wait for busy to reach a level
	task automatic wait_busy(input logic want, input int limit);
		// Look just after the edge, once the registered output has settled
		for (int n = 0; n < limit && busy !== want; n++) begin
			@(posedge clk);
			#1;
		end
		check_byte("busy", {7'h00, want}, {7'h00, busy});
	endtask : wait_busy
	task automatic t_refused();
		prog_u.xfer(32'hC0_07_FF_5A, resp);
		rd("dm unenabled", 32'hA0_07_FF_00, 8'h00, 8'hFF);
	endtask : t_refused
	task automatic t_enable();
		prog_u.xfer(32'hAC_53_00_00, resp);
		check_byte("echo", 8'h53, resp[15:8]);
		for (int n = 0; n < 20 && prog_enabled !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		check_byte("enabled", 8'h01, {7'h00, prog_enabled});
	endtask : t_enable
	task automatic t_erase();
		prog_u.xfer(32'hAC_9F_12_34, resp);
		wait_busy(1'b1, 20);
		wait_busy(1'b0, 33000);
		rd("pm erased", 32'h20_7F_FF_00, 8'hFF, 8'hFF);
		rd("dm erased", 32'hA0_07_FF_00, 8'hFF, 8'hFF);
	endtask : t_erase
	// Word 0x185 sits in page 3; low byte loaded before high
	task automatic t_page();
		prog_u.xfer(32'h40_00_05_12, resp);
		prog_u.xfer(32'h48_00_05_34, resp);
		prog_u.xfer(32'h4C_01_80_00, resp);
		wait_busy(1'b1, 20);
		rd("pm polled", 32'h28_01_85_00, 8'hFF, 8'hFF);
		wait_busy(1'b0, FLASH_N + 20);
		rd("pm low", 32'h20_01_85_00, 8'h12, 8'hFF);
		rd("pm high", 32'h28_01_85_00, 8'h34, 8'hFF);
		rd("pm page 0", 32'h20_00_05_00, 8'hFF, 8'hFF);
	endtask : t_page
	task automatic t_data();
		prog_u.xfer(32'hC0_FF_FF_5A, resp);
		rd("dm top", 32'hA0_07_FF_00, 8'h5A, 8'hFF);
		rd("dm other", 32'hA0_03_FF_00, 8'hFF, 8'hFF);
	endtask : t_data
	task automatic t_lock_fuse();
		logic [7:0] sub_wr [3] = '{8'hA0, 8'hA8, 8'hA4};
		logic [15:0] rd_op [3] = '{16'h50_00, 16'h58_08, 16'h50_08};
		logic [7:0] mask [3] = '{8'hFF, 8'hFF, 8'h03};
		rd("lock reset", 32'h58_00_00_00, 8'h3F, 8'h3F);
		prog_u.xfer(32'hAC_E0_00_F5, resp);
		rd("lock", 32'h58_00_00_00, 8'h35, 8'h3F);
		for (int k = 0; k < 3; k++) begin
			prog_u.xfer({8'hAC, sub_wr[k], 16'h00A6}, resp);
			rd("fuse", {rd_op[k], 16'h0000}, 8'hA6 & mask[k], mask[k]);
		end
	endtask : t_lock_fuse
	task automatic t_release();
		@(posedge clk) #1 dev_reset_n = 1'b1;
		repeat (6) @(posedge clk);
		#1 check_byte("enabled", 8'h00, {7'h00, prog_enabled});
		// Back under reset pin: a write before the enable must leave the byte alone
		dev_reset_n = 1'b0;
		repeat (4) @(posedge clk);
		#1 prog_u.xfer(32'hC0_07_FF_00, resp);
		t_enable();
		rd("dm kept", 32'hA0_07_FF_00, 8'h5A, 8'hFF);
	endtask : t_release
	// Main sequence
	initial begin
		reset = 1'b1;
		dev_reset_n = 1'b0;
		repeat (12) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		t_refused();
		t_enable();
		t_erase();
		t_page();
		t_data();
		t_lock_fuse();
		t_release();
		stop_test();
	end
	// Watchdog: run is near 0.5 ms, mostly erase; kept under the cycle budget of a hang
	initial begin
		#800_000;
		err_count++;
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
